//--- logic/cpu_iface_priority_ack.sv
// Processor interface: priority mask, binary point and interrupt acknowledge
`timescale 1ns/1ps
module cpu_iface_priority_ack #(
  parameter int NUM_IRQ = 32,
  parameter int PRIO_LEVELS = cpu_iface_pkg::PRIO_LEVELS_DEFAULT,
  parameter bit SECURITY = 1'b1,
  parameter logic [2:0] BP_MIN_S = cpu_iface_pkg::BP_MIN_S_DEFAULT,
  parameter logic [2:0] BP_MIN_NS = cpu_iface_pkg::BP_MIN_NS_DEFAULT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_nonsecure,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Distributor state
  input wire logic dist_en_grp0,
  input wire logic dist_en_grp1,
  input wire logic [NUM_IRQ-1:0] pend,
  input wire logic [NUM_IRQ*8-1:0] prio,
  input wire logic [NUM_IRQ-1:0] grp1,
  input wire logic [47:0] sgi_source,
  // Acknowledge claim towards the distributor
  output logic claim_req,
  output logic [9:0] claim_id,
  input wire logic claim_done,
  input wire logic claim_granted,
  // Processor side
  output logic irq,
  output logic [7:0] group_prio,
  output logic group_prio_grp1
);

  // Fewer levels leave the low priority bits unimplemented: 128 drops bit 0, 32 drops bits 2:0
  localparam logic [7:0] P_MASK = 8'(9'h100 - 9'(cpu_iface_pkg::PRIO_LEVELS_DEFAULT / PRIO_LEVELS));
  localparam logic [7:0] P_MASK_N = ~P_MASK;
  localparam logic [7:0] IMPL_MASK = ~P_MASK_N;

  typedef struct packed {
    cpu_iface_pkg::bus_state_t bus;
    logic en_grp0;
    logic en_grp1;
    logic ack_ctl;
    logic common_split_point_select;
    logic [7:0] pmr;
    logic [2:0] bp_s;
    logic [2:0] bp_ns;
    logic waitreq;
    logic [31:0] rdata;
    logic irq;
    logic claim_req;
    logic [9:0] claim_id;
    logic [2:0] claim_cpu;
    logic [7:0] group_prio;
    logic group_grp1;
    logic req_wr;
    logic req_ns;
    logic [5:0] req_addr;
    logic [7:0] req_wdata;
  } st_t;

  localparam st_t ST_RESET = '{
    bus: cpu_iface_pkg::BUS_IDLE,
    en_grp0: 1'b0,
    en_grp1: 1'b0,
    ack_ctl: 1'b0,
    common_split_point_select: 1'b0,
    pmr: cpu_iface_pkg::PMR_RESET,
    bp_s: BP_MIN_S,
    bp_ns: BP_MIN_NS,
    waitreq: 1'b1,
    rdata: 32'h0000_0000,
    irq: 1'b0,
    claim_req: 1'b0,
    claim_id: 10'h000,
    claim_cpu: 3'h0,
    group_prio: 8'h00,
    group_grp1: 1'b0,
    req_wr: 1'b0,
    req_ns: 1'b0,
    req_addr: 6'h00,
    req_wdata: 8'h00
  };

  st_t s_q;
  st_t s_d;

  logic hp_found;
  logic [9:0] hp_id;
  logic [7:0] hp_prio;
  logic hp_grp1;

  hppi_select #(
    .NUM_IRQ(NUM_IRQ),
    .ID_W(10)
  ) u_select (
    .pend(pend),
    .prio(prio),
    .grp1(grp1),
    .mask_level(s_q.pmr),
    .found(hp_found),
    .hp_id(hp_id),
    .hp_prio(hp_prio),
    .hp_grp1(hp_grp1)
  );

  // Acknowledge answer for a given security view; used by both acknowledge registers
  function automatic logic [9:0] ack_answer(input logic ns, input logic ack_ctl, input logic grp_on0,
                                            input logic grp_on1);
    logic [9:0] id;
    id = hp_id;
    if (!hp_found) begin
      id = cpu_iface_pkg::ID_SPURIOUS;
    end else if (hp_grp1 ? !grp_on1 : !grp_on0) begin
      id = cpu_iface_pkg::ID_SPURIOUS;
    end else if (!hp_grp1) begin
      if (ns) begin
        id = cpu_iface_pkg::ID_SPURIOUS;
      end
    end else if (!ns && !ack_ctl) begin
      id = cpu_iface_pkg::ID_GRP1_PENDING;
    end
    return id;
  endfunction : ack_answer

  // Clamp a binary point write to the copy's implemented minimum
  function automatic logic [2:0] clamp_bp(input logic [2:0] v, input logic [2:0] min_v);
    return (v < min_v) ? min_v : v;
  endfunction : clamp_bp

  // Requesting processor number, only meaningful for software-generated interrupts
  function automatic logic [2:0] sgi_cpu(input logic [9:0] id);
    logic [2:0] c;
    c = 3'h0;
    if (id < cpu_iface_pkg::ID_SGI_LIMIT) begin
      c = sgi_source[id[3:0]*3 +: 3];
    end
    return c;
  endfunction : sgi_cpu

  logic ns_now;
  logic grp_on0;
  logic grp_on1;
  logic [7:0] pmr_ns_view;
  logic [9:0] ans;
  logic [2:0] bp_sel;
  logic use_ns_copy;
  logic [7:0] gp_mask;

  always_comb begin
    s_d = s_q;
    // Without security every access behaves as secure
    ns_now = SECURITY && avs_nonsecure;
    grp_on0 = dist_en_grp0 && s_q.en_grp0;
    grp_on1 = dist_en_grp1 && s_q.en_grp1;
    ans = cpu_iface_pkg::ID_SPURIOUS;
    pmr_ns_view = 8'h00;
    if (s_q.pmr[7]) begin
      pmr_ns_view = 8'((s_q.pmr & IMPL_MASK) << 1);
    end

    // Request line follows the live selection, so a source that drops withdraws it
    s_d.irq = hp_found && (hp_grp1 ? grp_on1 : grp_on0);

    // Group priority of the current candidate for preemption decisions
    use_ns_copy = SECURITY && hp_grp1 && !s_q.common_split_point_select;
    bp_sel = use_ns_copy ? s_q.bp_ns : s_q.bp_s;
    // The non-secure copy keeps one more group bit than the same secure value
    gp_mask = use_ns_copy ? 8'(8'hFF << bp_sel) : 8'(8'hFE << bp_sel);
    s_d.group_prio = hp_prio & gp_mask;
    s_d.group_grp1 = hp_grp1;

    case (s_q.bus)
      cpu_iface_pkg::BUS_IDLE: begin
        s_d.waitreq = 1'b1;
        if (avs_write) begin
          s_d.req_wr = 1'b1;
          s_d.req_ns = ns_now;
          s_d.req_addr = avs_address;
          s_d.req_wdata = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
          s_d.req_addr = avs_byteenable[0] ? avs_address : 6'h3F;
          s_d.waitreq = 1'b0;
          s_d.bus = cpu_iface_pkg::BUS_RESP;
        end else if (avs_read) begin
          s_d.req_wr = 1'b0;
          s_d.rdata = 32'h0000_0000;
          s_d.waitreq = 1'b0;
          s_d.bus = cpu_iface_pkg::BUS_RESP;
          case (avs_address)
            cpu_iface_pkg::OFS_CTRL: begin
              if (ns_now) begin
                s_d.rdata[cpu_iface_pkg::CTRL_NS_EN_GRP1] = s_q.en_grp1;
              end else begin
                s_d.rdata[cpu_iface_pkg::CTRL_EN_GRP0] = s_q.en_grp0;
                s_d.rdata[cpu_iface_pkg::CTRL_EN_GRP1] = s_q.en_grp1;
                s_d.rdata[cpu_iface_pkg::CTRL_ACK_CTL] = s_q.ack_ctl;
                s_d.rdata[cpu_iface_pkg::CTRL_COMMON_SPLIT_POINT_SELECT] = s_q.common_split_point_select;
              end
            end
            cpu_iface_pkg::OFS_PMR: begin
              s_d.rdata[7:0] = ns_now ? pmr_ns_view : s_q.pmr;
            end
            cpu_iface_pkg::OFS_BPR: begin
              s_d.rdata[2:0] = ns_now ? s_q.bp_ns : s_q.bp_s;
            end
            cpu_iface_pkg::OFS_ABPR: begin
              if (SECURITY && !ns_now) begin
                s_d.rdata[2:0] = s_q.bp_ns;
              end
            end
            cpu_iface_pkg::OFS_IAR, cpu_iface_pkg::OFS_AIAR: begin
              if (avs_address == cpu_iface_pkg::OFS_IAR) begin
                ans = ack_answer(ns_now, s_q.ack_ctl, grp_on0, grp_on1);
              end else if (SECURITY && !ns_now) begin
                // Alias gives secure software the non-secure acknowledge view
                ans = ack_answer(1'b1, s_q.ack_ctl, grp_on0, grp_on1);
              end
              if (ans < cpu_iface_pkg::ID_FIRST_SPECIAL) begin
                // Claim must be won at the distributor before the ID is handed out
                s_d.claim_req = 1'b1;
                s_d.claim_id = ans;
                s_d.claim_cpu = sgi_cpu(ans);
                s_d.waitreq = 1'b1;
                s_d.bus = cpu_iface_pkg::BUS_CLAIM;
              end else begin
                s_d.rdata[9:0] = ans;
              end
            end
            default: begin
              s_d.rdata = 32'h0000_0000;
            end
          endcase
        end
      end
      cpu_iface_pkg::BUS_CLAIM: begin
        s_d.waitreq = 1'b1;
        if (claim_done) begin
          s_d.claim_req = 1'b0;
          s_d.waitreq = 1'b0;
          s_d.bus = cpu_iface_pkg::BUS_RESP;
          s_d.rdata = 32'h0000_0000;
          if (claim_granted) begin
            s_d.rdata[cpu_iface_pkg::IAR_ID_LSB +: 10] = s_q.claim_id;
            s_d.rdata[cpu_iface_pkg::IAR_CPU_LSB +: 3] = s_q.claim_cpu;
          end else begin
            // Another processor took it first
            s_d.rdata[9:0] = cpu_iface_pkg::ID_SPURIOUS;
          end
        end
      end
      cpu_iface_pkg::BUS_RESP: begin
        // The write lands on the edge at which the master sees waitrequest low
        s_d.waitreq = 1'b1;
        s_d.bus = cpu_iface_pkg::BUS_IDLE;
        if (s_q.req_wr) begin
          s_d.req_wr = 1'b0;
          case (s_q.req_addr)
            cpu_iface_pkg::OFS_CTRL: begin
              if (s_q.req_ns) begin
                s_d.en_grp1 = s_q.req_wdata[cpu_iface_pkg::CTRL_NS_EN_GRP1];
              end else begin
                s_d.en_grp0 = s_q.req_wdata[cpu_iface_pkg::CTRL_EN_GRP0];
                s_d.en_grp1 = s_q.req_wdata[cpu_iface_pkg::CTRL_EN_GRP1];
                s_d.ack_ctl = s_q.req_wdata[cpu_iface_pkg::CTRL_ACK_CTL];
                s_d.common_split_point_select = s_q.req_wdata[cpu_iface_pkg::CTRL_COMMON_SPLIT_POINT_SELECT];
              end
            end
            cpu_iface_pkg::OFS_PMR: begin
              if (!s_q.req_ns) begin
                s_d.pmr = s_q.req_wdata & IMPL_MASK;
              end else if (s_q.pmr[7]) begin
                s_d.pmr = (cpu_iface_pkg::PMR_NS_FORCE | (s_q.req_wdata >> 1)) & IMPL_MASK;
              end
            end
            cpu_iface_pkg::OFS_BPR: begin
              if (s_q.req_ns) begin
                s_d.bp_ns = clamp_bp(s_q.req_wdata[2:0], BP_MIN_NS);
              end else begin
                s_d.bp_s = clamp_bp(s_q.req_wdata[2:0], BP_MIN_S);
              end
            end
            cpu_iface_pkg::OFS_ABPR: begin
              if (SECURITY && !s_q.req_ns) begin
                s_d.bp_ns = clamp_bp(s_q.req_wdata[2:0], BP_MIN_NS);
              end
            end
            default: begin
              s_d.req_wr = 1'b0;
            end
          endcase
        end
      end
      default: begin
        s_d.bus = cpu_iface_pkg::BUS_IDLE;
        s_d.waitreq = 1'b1;
      end
    endcase
  end

  // Unimplemented low priority bits never hold a one, so they read zero
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_q <= ST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.waitreq;
  assign claim_req = s_q.claim_req;
  assign claim_id = s_q.claim_id;
  assign irq = s_q.irq;
  assign group_prio = s_q.group_prio;
  assign group_prio_grp1 = s_q.group_grp1;

endmodule : cpu_iface_priority_ack

//--- logic/cpu_iface_pkg.sv
// Shared constants and types for the processor interface priority and acknowledge block
package cpu_iface_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_PMR = 6'h04;
  localparam logic [5:0] OFS_BPR = 6'h08;
  localparam logic [5:0] OFS_IAR = 6'h0C;
  localparam logic [5:0] OFS_ABPR = 6'h1C;
  localparam logic [5:0] OFS_AIAR = 6'h20;
  // End-of-interrupt is handled outside this block, so writes here are ignored
  localparam logic [5:0] OFS_EOIR = 6'h10;

  // Control register field positions
  localparam int CTRL_EN_GRP0 = 0;
  localparam int CTRL_EN_GRP1 = 1;
  localparam int CTRL_ACK_CTL = 2;
  localparam int CTRL_COMMON_SPLIT_POINT_SELECT = 4;
  // Non-secure view of the control register holds only the Group 1 enable
  localparam int CTRL_NS_EN_GRP1 = 0;

  // Acknowledge register field positions
  localparam int IAR_ID_LSB = 0;
  localparam int IAR_CPU_LSB = 10;

  // Special interrupt numbers
  localparam logic [9:0] ID_SPURIOUS = 10'h3FF;
  localparam logic [9:0] ID_GRP1_PENDING = 10'h3FE;
  localparam logic [9:0] ID_FIRST_SPECIAL = 10'h3FC;
  localparam logic [9:0] ID_SGI_LIMIT = 10'h010;

  // Reset values and implementation constants
  localparam logic [7:0] PMR_RESET = 8'h00;
  localparam logic [7:0] PMR_NS_FORCE = 8'h80;
  localparam logic [2:0] BP_MIN_S_DEFAULT = 3'h2;
  localparam logic [2:0] BP_MIN_NS_DEFAULT = 3'h3;
  localparam int PRIO_LEVELS_DEFAULT = 256;

  typedef enum logic [1:0] {BUS_IDLE, BUS_CLAIM, BUS_RESP} bus_state_t;

endpackage : cpu_iface_pkg

//--- logic/hppi_select.sv
// Highest-priority pending interrupt selector behind the priority mask filter
`timescale 1ns/1ps
module hppi_select #(
  parameter int NUM_IRQ = 32,
  parameter int ID_W = 10
) (
  // Distributor state
  input wire logic [NUM_IRQ-1:0] pend,
  input wire logic [NUM_IRQ*8-1:0] prio,
  input wire logic [NUM_IRQ-1:0] grp1,
  // Filter level
  input wire logic [7:0] mask_level,
  // Result
  output logic found,
  output logic [ID_W-1:0] hp_id,
  output logic [7:0] hp_prio,
  output logic hp_grp1
);

  logic [NUM_IRQ-1:0] eligible;

  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++) begin : g_filt
      // Lower value is higher priority; equal to the level is not enough
      assign eligible[g] = pend[g] && (prio[g*8 +: 8] < mask_level);
    end
  endgenerate

  // Strictly lower value wins, so a tie goes to the lowest ID
  always_comb begin
    found = 1'b0;
    hp_id = '0;
    hp_prio = 8'hFF;
    hp_grp1 = 1'b0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (eligible[i] && (!found || prio[i*8 +: 8] < hp_prio)) begin
        found = 1'b1;
        hp_id = ID_W'(i);
        hp_prio = prio[i*8 +: 8];
        hp_grp1 = grp1[i];
      end
    end
  end

endmodule : hppi_select

//--- tb/claim_responder.sv
// Distributor stand-in answering acknowledge claims
`timescale 1ns/1ps
module claim_responder (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Claim link
  input wire logic claim_req,
  output logic claim_done,
  output logic claim_granted,
  // Bench control
  input wire logic [3:0] delay,
  input wire logic grant
);
  logic [3:0] cnt_q;
  always_ff @(posedge mclk) begin
    claim_done <= 1'b0;
    // Outcome toggles outside the answer cycle so nothing may rely on it
    claim_granted <= resetn ? ~claim_granted : 1'b0;
    if (!resetn || !claim_req) begin
      cnt_q <= 4'h0;
    end else if (!claim_done) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == delay) begin
        claim_done <= 1'b1;
        claim_granted <= grant;
      end
    end
  end
endmodule : claim_responder

//--- tb/cpu_iface_priority_ack_properties.sv
// Port assertions for the processor interface block
`timescale 1ns/1ps
module cpu_iface_priority_ack_properties #(
  parameter int NUM_IRQ = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Register bus
  input wire logic avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Distributor
  input wire logic dist_en_grp0,
  input wire logic dist_en_grp1,
  input wire logic [NUM_IRQ-1:0] pend,
  input wire logic claim_req,
  input wire logic [9:0] claim_id,
  input wire logic claim_done,
  input wire logic claim_granted,
  // Processor
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_claim_hold: assert property (claim_req && !claim_done |=> claim_req && $stable(claim_id))
    else $error("claim dropped or changed before answer");
  a_claim_cause: assert property ($rose(claim_req) |-> $past(avs_read))
    else $error("claim without acknowledge read");
  a_claim_answer: assert property (claim_req && claim_done |=> !claim_req && !avs_waitrequest)
    else $error("answered claim not closed");
  a_claim_range: assert property (claim_req |-> claim_id < 10'h3FC)
    else $error("claim for special id");
  a_lost_claim: assert property (claim_req && claim_done && !claim_granted |=> avs_readdata == 32'h0000_03FF)
    else $error("lost claim not spurious");
  a_won_claim: assert property (claim_req && claim_done && claim_granted |=>
    avs_readdata[9:0] == $past(claim_id) && avs_readdata[31:13] == 19'h0)
    else $error("won claim data wrong");
  a_idle_irq: assert property (!(|pend) |=> !irq)
    else $error("request without pending");
  a_off_irq: assert property (!dist_en_grp0 && !dist_en_grp1 |=> !irq)
    else $error("request while forwarding off");
  a_off_claim: assert property (!dist_en_grp0 && !dist_en_grp1 |=> !$rose(claim_req))
    else $error("claim while forwarding off");
endmodule : cpu_iface_priority_ack_properties

bind cpu_iface_priority_ack cpu_iface_priority_ack_properties #(.NUM_IRQ(NUM_IRQ)) props_u (
  .mclk(mclk), .resetn(resetn), .avs_read(avs_read), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .dist_en_grp0(dist_en_grp0), .dist_en_grp1(dist_en_grp1),
  .pend(pend), .claim_req(claim_req), .claim_id(claim_id), .claim_done(claim_done),
  .claim_granted(claim_granted), .irq(irq)
);

//--- tb/cpu_iface_priority_ack_tb_top.sv
// Directed bench for the processor interface block
`timescale 1ns/1ps
module cpu_iface_priority_ack_tb_top;
  logic mclk, resetn, avs_read, avs_write, avs_nonsecure, avs_waitrequest, grant;
  logic dist_en_grp0, dist_en_grp1, claim_req, claim_done, claim_granted, irq, group_prio_grp1;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, pend, grp1;
  logic [3:0] avs_byteenable, delay;
  logic [255:0] prio;
  logic [47:0] sgi_source;
  logic [9:0] claim_id;
  logic [7:0] group_prio;
  int bad_count, comparisons;

  // Fewer priority levels so the unimplemented mask bits are exercised
  cpu_iface_priority_ack #(.PRIO_LEVELS(32)) dut_u (.mclk(mclk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_nonsecure(avs_nonsecure), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dist_en_grp0(dist_en_grp0), .dist_en_grp1(dist_en_grp1),
    .pend(pend), .prio(prio), .grp1(grp1), .sgi_source(sgi_source), .claim_req(claim_req),
    .claim_id(claim_id), .claim_done(claim_done), .claim_granted(claim_granted), .irq(irq),
    .group_prio(group_prio), .group_prio_grp1(group_prio_grp1));
  claim_responder peer_u (.mclk(mclk), .resetn(resetn), .claim_req(claim_req), .claim_done(claim_done),
    .claim_granted(claim_granted), .delay(delay), .grant(grant));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic bus(input logic wr, input logic [5:0] a, input logic ns, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_nonsecure <= ns;
    // No cycle budget here: a hung slave is caught by the watchdog
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Idle edge keeps two requests out of one time step
    @(posedge mclk);
  endtask : bus

  task automatic rchk(input logic [5:0] a, input logic ns, input logic [31:0] exp);
    bus(1'b0, a, ns, 32'h0);
    check(rd, exp);
  endtask : rchk

  task automatic set_irq(input int id, input logic [7:0] p, input logic g);
    pend <= 32'h1 << id;
    prio[id*8+:8] <= p;
    grp1[id] <= g;
  endtask : set_irq

  task automatic t_mask();
    rchk(cpu_iface_pkg::OFS_PMR, 1'b0, 32'h0);
    bus(1'b1, cpu_iface_pkg::OFS_PMR, 1'b0, 32'hFF);
    rchk(cpu_iface_pkg::OFS_PMR, 1'b0, 32'hF8);
    rchk(cpu_iface_pkg::OFS_PMR, 1'b1, 32'hF0);
    bus(1'b1, cpu_iface_pkg::OFS_PMR, 1'b1, 32'h40);
    rchk(cpu_iface_pkg::OFS_PMR, 1'b0, 32'hA0);
    bus(1'b1, cpu_iface_pkg::OFS_PMR, 1'b0, 32'h70);
    rchk(cpu_iface_pkg::OFS_PMR, 1'b1, 32'h0);
    bus(1'b1, cpu_iface_pkg::OFS_PMR, 1'b1, 32'h10);
    rchk(cpu_iface_pkg::OFS_PMR, 1'b0, 32'h70);
  endtask : t_mask

  task automatic t_split();
    rchk(cpu_iface_pkg::OFS_BPR, 1'b0, 32'h2);
    rchk(cpu_iface_pkg::OFS_BPR, 1'b1, 32'h3);
    rchk(cpu_iface_pkg::OFS_ABPR, 1'b0, 32'h3);
    bus(1'b1, cpu_iface_pkg::OFS_BPR, 1'b0, 32'h0);
    rchk(cpu_iface_pkg::OFS_BPR, 1'b0, 32'h2);
    bus(1'b1, cpu_iface_pkg::OFS_BPR, 1'b1, 32'h1);
    rchk(cpu_iface_pkg::OFS_BPR, 1'b1, 32'h3);
    bus(1'b1, cpu_iface_pkg::OFS_ABPR, 1'b0, 32'h5);
    rchk(cpu_iface_pkg::OFS_BPR, 1'b1, 32'h5);
    rchk(cpu_iface_pkg::OFS_ABPR, 1'b1, 32'h0);
    rchk(6'h10, 1'b0, 32'h0);
  endtask : t_split

  task automatic t_ack();
    bus(1'b1, cpu_iface_pkg::OFS_PMR, 1'b0, 32'hFF);
    bus(1'b1, cpu_iface_pkg::OFS_CTRL, 1'b0, 32'h3);
    set_irq(5, 8'h47, 1'b0);
    tick(2);
    check(irq, 1'b1);
    check(group_prio, 8'h40);
    check(group_prio_grp1, 1'b0);
    rchk(cpu_iface_pkg::OFS_IAR, 1'b1, 32'h3FF);
    rchk(cpu_iface_pkg::OFS_IAR, 1'b0, 32'h5);
    bus(1'b1, cpu_iface_pkg::OFS_EOIR, 1'b0, rd);
    set_irq(3, 8'h37, 1'b1);
    sgi_source[9+:3] <= 3'h6;
    tick(2);
    check(group_prio, 8'h20);
    check(group_prio_grp1, 1'b1);
    rchk(cpu_iface_pkg::OFS_IAR, 1'b0, 32'h3FE);
    rchk(cpu_iface_pkg::OFS_AIAR, 1'b1, 32'h3FF);
    rchk(cpu_iface_pkg::OFS_AIAR, 1'b0, 32'h1803);
    bus(1'b1, cpu_iface_pkg::OFS_EOIR, 1'b0, rd);
    delay <= 4'h5;
    rchk(cpu_iface_pkg::OFS_IAR, 1'b1, 32'h1803);
    bus(1'b1, cpu_iface_pkg::OFS_EOIR, 1'b1, rd);
    bus(1'b1, cpu_iface_pkg::OFS_CTRL, 1'b0, 32'h17);
    tick(2);
    check(group_prio, 8'h30);
    grant <= 1'b0;
    rchk(cpu_iface_pkg::OFS_IAR, 1'b0, 32'h3FF);
    grant <= 1'b1;
    set_irq(3, 8'hF8, 1'b1);
    tick(2);
    check(irq, 1'b0);
    rchk(cpu_iface_pkg::OFS_IAR, 1'b1, 32'h3FF);
    set_irq(3, 8'hF0, 1'b1);
    tick(2);
    check(irq, 1'b1);
    {dist_en_grp0, dist_en_grp1} <= 2'b00;
    tick(2);
    check(irq, 1'b0);
    rchk(cpu_iface_pkg::OFS_IAR, 1'b1, 32'h3FF);
    {dist_en_grp0, dist_en_grp1} <= 2'b11;
    pend <= 32'h0;
    tick(2);
    check(irq, 1'b0);
    rchk(cpu_iface_pkg::OFS_IAR, 1'b0, 32'h3FF);
  endtask : t_ack

  initial begin
    {resetn, avs_read, avs_write, avs_nonsecure, avs_address, avs_writedata} <= '0;
    {pend, prio, grp1, sgi_source, delay} <= '0;
    avs_byteenable <= 4'hF;
    {dist_en_grp0, dist_en_grp1, grant} <= 3'h7;
    bad_count = 0;
    comparisons = 0;
    tick(2);
    resetn <= 1'b1;
    tick(1);
    t_mask();
    t_split();
    t_ack();
    end_sim();
  end

  initial begin
    tick(3000);
    bad_count++;
    end_sim();
  end
endmodule : cpu_iface_priority_ack_tb_top
